// ===== irq_wake_pkg.sv
// Shared constants for the pending-request clear and stop wake-up block.
// Assumes a 32-bit AXI4-Lite register bus that carries full byte addresses.
package irq_wake_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_PENDING_CLEAR = 32'hFFFF_E060;
    localparam logic [31:0] ADDR_CFG_A         = 32'hFFFF_EE10;
    localparam logic [31:0] ADDR_CFG_B         = 32'hFFFF_EE14;
    localparam logic [31:0] ADDR_STATUS        = 32'hFFFF_EF00;
    localparam logic [31:0] ADDR_MASK          = 32'hFFFF_EF04;
    localparam logic [31:0] ADDR_PENDING_LO    = 32'hFFFF_EF08;
    localparam logic [31:0] ADDR_PENDING_HI    = 32'hFFFF_EF0C;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int PIN_COUNT          = 4;
    localparam int SOURCE_COUNT       = 64;
    localparam int CLEAR_FIELD_WIDTH  = 6;
    localparam int LANE_WIDTH         = 8;
    localparam int SENSE_LSB          = 4;
    localparam int ENABLE_BIT         = 0;

    // ------------------------------------------------------------------
    // Sensitivity codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SENSE_LOW_LEVEL    = 2'h0;
    localparam logic [1:0] SENSE_HIGH_LEVEL   = 2'h1;
    localparam logic [1:0] SENSE_FALLING_EDGE = 2'h2;
    localparam logic [1:0] SENSE_RISING_EDGE  = 2'h3;

    // ------------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_A_RESET    = 32'h2020_2020;
    localparam logic [31:0] CFG_A_WRITABLE = 32'h3131_3131;
    localparam logic [31:0] CFG_B_RESET    = 32'h0000_0000;
    localparam logic [3:0]  MASK_RESET     = 4'h0;

    // ------------------------------------------------------------------
    // Bus responses and register selection
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        SEL_CLEAR,
        SEL_CFG_A,
        SEL_CFG_B,
        SEL_STATUS,
        SEL_MASK,
        SEL_PENDING_LO,
        SEL_PENDING_HI,
        SEL_NONE
    } reg_sel_t;

endpackage : irq_wake_pkg

// ===== wake_detect.sv
// One external pin's stop wake-up detector with registered output.
// Assumes the pin is already synchronous to i_clock.
`timescale 1ns/1ns
module wake_detect
    import irq_wake_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_pin,
    input  wire logic [1:0] i_sense,
    input  wire logic       i_enable,
    output logic            o_wake
);

    logic prev_pin;
    logic hit;

    // ------------------------------------------------------------------
    // Condition selection
    // ------------------------------------------------------------------
    always_comb
    begin
        case (i_sense)
            SENSE_LOW_LEVEL:    hit = !i_pin;
            SENSE_HIGH_LEVEL:   hit = i_pin;
            SENSE_FALLING_EDGE: hit = prev_pin && !i_pin;
            SENSE_RISING_EDGE:  hit = !prev_pin && i_pin;
            default:            hit = 1'b0;
        endcase
    end

    // The previous sample resets low so a pin held low at reset is no falling edge.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            prev_pin <= 1'b0;
        else
            prev_pin <= i_pin;
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_wake <= 1'b0;
        else
            o_wake <= i_enable && hit;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_disabled_quiet;
        @(posedge i_clock) disable iff (!i_rst_n)
        !i_enable |=> !o_wake;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("Disabled pin signalled wake-up.");

    sequence s_fall;
        i_pin ##1 (!i_pin && i_enable && i_sense == SENSE_FALLING_EDGE);
    endsequence
    property p_falling;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_fall |=> o_wake;
    endproperty
    a_falling: assert property (p_falling)
        else $error("Falling edge missed.");

    property p_rising_only_on_edge;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_sense == SENSE_RISING_EDGE && i_pin && $past(i_pin)) |=> !o_wake;
    endproperty
    a_rising_only_on_edge: assert property (p_rising_only_on_edge)
        else $error("Rising sense fired without an edge.");

    property p_low_level;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_enable && i_sense == SENSE_LOW_LEVEL) |=> (o_wake == !$past(i_pin));
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("Low level sense wrong.");

endmodule : wake_detect

// ===== irq_clear_and_stop_wakeup.sv
// Pending-request clear register and stop wake-up configuration, AXI4-Lite slave.
// Assumes synchronous source request pulses and synchronous external pins.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

// Functional notes
// - Clear field write clears named pending source.
// - Two-bit sense selects level or edge.
// - Per-pin enable gates stop wake-up signal.
// - Pin n sits in byte lane n.
// - Reset: falling edge sense, enables zero.
module irq_clear_and_stop_wakeup
    import irq_wake_pkg::*;
(
    input  wire logic                    i_clock,
    input  wire logic                    i_resetn,
    input  wire logic                    i_awvalid,
    output logic                         o_awready,
    input  wire logic [31:0]             i_awaddr,
    input  wire logic                    i_wvalid,
    output logic                         o_wready,
    input  wire logic [31:0]             i_wdata,
    input  wire logic [3:0]              i_wstrb,
    output logic                         o_bvalid,
    input  wire logic                    i_bready,
    output logic [1:0]                   o_bresp,
    input  wire logic                    i_arvalid,
    output logic                         o_arready,
    input  wire logic [31:0]             i_araddr,
    output logic                         o_rvalid,
    input  wire logic                    i_rready,
    output logic [31:0]                  o_rdata,
    output logic [1:0]                   o_rresp,
    input  wire logic [SOURCE_COUNT-1:0] i_source_request,
    output logic [SOURCE_COUNT-1:0]      o_pending_request,
    input  wire logic [PIN_COUNT-1:0]    i_ext_irq_pin,
    output logic                         o_stop_wakeup,
    output logic                         o_irq
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            {rst_n, rst_meta_n} <= 2'h0;
        else
            {rst_n, rst_meta_n} <= {rst_meta_n, 1'b1};
    end

    function automatic reg_sel_t reg_decode(input logic [31:0] addr);
        case (addr)
            ADDR_PENDING_CLEAR: return SEL_CLEAR;
            ADDR_CFG_A:         return SEL_CFG_A;
            ADDR_CFG_B:         return SEL_CFG_B;
            ADDR_STATUS:        return SEL_STATUS;
            ADDR_MASK:          return SEL_MASK;
            ADDR_PENDING_LO:    return SEL_PENDING_LO;
            ADDR_PENDING_HI:    return SEL_PENDING_HI;
            default:            return SEL_NONE;
        endcase
    endfunction : reg_decode

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        write_fire;
    logic        next_aw_held;
    logic        next_w_held;
    reg_sel_t    write_sel;
    assign write_fire   = aw_held && w_held && !o_bvalid;
    assign next_aw_held = write_fire ? 1'b0 : (aw_held || (i_awvalid && o_awready));
    assign next_w_held  = write_fire ? 1'b0 : (w_held || (i_wvalid && o_wready));
    assign write_sel    = reg_decode(aw_addr);

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            aw_addr   <= 32'h0000_0000;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
        end
        else
        begin
            aw_held   <= next_aw_held;
            w_held    <= next_w_held;
            o_awready <= !next_aw_held;
            o_wready  <= !next_w_held;
            if (i_awvalid && o_awready)
                aw_addr <= i_awaddr;
            if (i_wvalid && o_wready)
            begin
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end
        else if (write_fire)
        begin
            o_bvalid <= 1'b1;
            o_bresp  <= (write_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (i_bready)
            o_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [31:0] cfg_a;
    logic [31:0] cfg_b;
    logic [3:0]  mask;

    // Byte strobes let software touch one pin's lane without disturbing the others.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_a <= CFG_A_RESET;
            cfg_b <= CFG_B_RESET;
            mask  <= MASK_RESET;
        end
        else if (write_fire)
        begin
            for (int lane = 0; lane < 4; lane++)
            begin
                if (w_strb[lane] && write_sel == SEL_CFG_A)
                    cfg_a[lane*8 +: 8] <= w_data[lane*8 +: 8] & CFG_A_WRITABLE[lane*8 +: 8];
                if (w_strb[lane] && write_sel == SEL_CFG_B)
                    cfg_b[lane*8 +: 8] <= w_data[lane*8 +: 8];
            end
            if (w_strb[0] && write_sel == SEL_MASK)
                mask <= w_data[PIN_COUNT-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Pending requests
    // ------------------------------------------------------------------
    logic                         clear_fire;
    logic [CLEAR_FIELD_WIDTH-1:0] clear_index;
    logic [SOURCE_COUNT-1:0]      clear_onehot;
    assign clear_fire   = write_fire && write_sel == SEL_CLEAR && w_strb[0];
    assign clear_index  = w_data[CLEAR_FIELD_WIDTH-1:0];
    assign clear_onehot = clear_fire ? (SOURCE_COUNT'(1) << clear_index) : '0;

    // A request arriving in the cycle of its clear stays pending.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_pending_request <= '0;
        else
            o_pending_request <= (o_pending_request & ~clear_onehot) | i_source_request;
    end

    // ------------------------------------------------------------------
    // Wake-up detection
    // ------------------------------------------------------------------
    logic [PIN_COUNT-1:0] wake_hits;
    generate
        for (genvar pin = 0; pin < PIN_COUNT; pin++)
        begin : g_pin
            wake_detect u_detect (
                .i_clock  (i_clock),
                .i_rst_n  (rst_n),
                .i_pin    (i_ext_irq_pin[pin]),
                .i_sense  (cfg_a[pin*LANE_WIDTH+SENSE_LSB +: 2]),
                .i_enable (cfg_a[pin*LANE_WIDTH+ENABLE_BIT]),
                .o_wake   (wake_hits[pin])
            );
        end
    endgenerate

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_stop_wakeup <= 1'b0;
        else
            o_stop_wakeup <= |wake_hits;
    end

    // ------------------------------------------------------------------
    // Read channel and interrupt status
    // ------------------------------------------------------------------
    logic                 read_take;
    logic                 next_rvalid;
    logic [PIN_COUNT-1:0] status;
    reg_sel_t             read_sel;
    assign read_take   = i_arvalid && o_arready;
    assign next_rvalid = read_take || (o_rvalid && !i_rready);
    assign read_sel    = reg_decode(i_araddr);

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end
        else
        begin
            o_rvalid  <= next_rvalid;
            o_arready <= !next_rvalid;
            if (read_take)
            begin
                o_rresp <= (read_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                case (read_sel)
                    SEL_CFG_A:      o_rdata <= cfg_a;
                    SEL_CFG_B:      o_rdata <= cfg_b;
                    SEL_STATUS:     o_rdata <= {28'h0000000, status};
                    SEL_MASK:       o_rdata <= {28'h0000000, mask};
                    SEL_PENDING_LO: o_rdata <= o_pending_request[31:0];
                    SEL_PENDING_HI: o_rdata <= o_pending_request[63:32];
                    default:        o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Reading status clears it, but a wake-up in that same cycle is kept.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            status <= '0;
        else if (read_take && read_sel == SEL_STATUS)
            status <= wake_hits;
        else
            status <= status | wake_hits;
    end

    // The interrupt lags the status bit by one cycle to keep the output registered.
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            o_irq <= 1'b0;
        else
            o_irq <= |(status & mask);
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_clear_named;
        @(posedge i_clock) disable iff (!rst_n)
        (clear_fire && !i_source_request[clear_index])
            |=> !o_pending_request[$past(clear_index)];
    endproperty
    a_clear_named: assert property (p_clear_named)
        else $error("Clear write left the source pending.");
    property p_clear_only_named;
        @(posedge i_clock) disable iff (!rst_n)
        1'b1 |=> ((o_pending_request & ~$past(clear_onehot))
                  == (($past(o_pending_request) | $past(i_source_request))
                      & ~$past(clear_onehot)));
    endproperty
    a_clear_only_named: assert property (p_clear_only_named)
        else $error("Other pending requests disturbed.");
    property p_set_wins;
        @(posedge i_clock) disable iff (!rst_n)
        1'b1 |=> ((o_pending_request & $past(i_source_request)) == $past(i_source_request));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("New request lost.");
    property p_cfg_reserved_zero;
        @(posedge i_clock) disable iff (!rst_n)
        (cfg_a & ~CFG_A_WRITABLE) == 32'h0000_0000;
    endproperty
    a_cfg_reserved_zero: assert property (p_cfg_reserved_zero)
        else $error("Reserved wake-up bits set.");
    property p_cfg_reset;
        @(posedge i_clock)
        $rose(rst_n) |-> cfg_a == CFG_A_RESET;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset)
        else $error("Wake-up configuration reset value wrong.");
    sequence s_b_stall;
        o_bvalid && !i_bready;
    endsequence
    property p_b_hold;
        @(posedge i_clock) disable iff (!rst_n)
        s_b_stall |=> o_bvalid && $stable(o_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("Write response dropped before taken.");
    property p_read_answer;
        @(posedge i_clock) disable iff (!rst_n)
        read_take |=> o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("Read not answered next cycle.");
    property p_status_clear;
        @(posedge i_clock) disable iff (!rst_n)
        (read_take && read_sel == SEL_STATUS && wake_hits == '0) |=> status == '0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Status not cleared by read.");
    property p_irq_follows;
        @(posedge i_clock) disable iff (!rst_n)
        ((status & mask) != '0) |=> o_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("Unmasked status did not raise interrupt.");
    property p_wakeup_follows;
        @(posedge i_clock) disable iff (!rst_n)
        (wake_hits != '0) |=> o_stop_wakeup;
    endproperty
    a_wakeup_follows: assert property (p_wakeup_follows)
        else $error("Stop wake-up not signalled.");
endmodule : irq_clear_and_stop_wakeup

// ===== core_pin_model.sv
// Behavioural model of the core request side and the four external pins.
// Assumes the bench changes its controls just after a rising edge.
`timescale 1ns/1ns
module core_pin_model
(
    input  wire logic        i_clock,
    input  wire logic [3:0]  i_pin_level,
    input  wire logic        i_fire,
    input  wire logic [5:0]  i_fire_index,
    output logic [3:0]       o_ext_irq_pin,
    output logic [63:0]      o_source_request
);

    // Requests are one-cycle pulses, the weakest form the block must accept.
    always @(posedge i_clock)
    begin
        o_ext_irq_pin    <= i_pin_level;
        o_source_request <= i_fire ? (64'h1 << i_fire_index) : 64'h0;
    end
endmodule : core_pin_model

// ===== test_irq_clear_and_stop_wakeup.sv
// Self-checking bench for the pending clear and stop wake-up block.
// Assumes the package constants and the hand-over bus timing.
`timescale 1ns/1ns
module test_irq_clear_and_stop_wakeup
    import irq_wake_pkg::*;
;
    logic i_clock = 0, i_resetn, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, fire = 0;
    logic awready, wready, bvalid, arready, rvalid, stop_wakeup, irq;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'h0, pin_level = 4'h0, ext_pin;
    logic [1:0]  bresp, rresp, rsp;
    logic [5:0]  fire_index = 6'h0;
    logic [63:0] source_request, pending;
    int failures = 0, checks = 0;

    // ------------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------------
    irq_clear_and_stop_wakeup u_irq_clear_and_stop_wakeup (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_source_request(source_request), .o_pending_request(pending),
        .i_ext_irq_pin(ext_pin), .o_stop_wakeup(stop_wakeup), .o_irq(irq));
    core_pin_model u_core_pin_model (
        .i_clock(i_clock), .i_pin_level(pin_level), .i_fire(fire),
        .i_fire_index(fire_index), .o_ext_irq_pin(ext_pin),
        .o_source_request(source_request));

    initial
    begin
        forever #50 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        checks++;
        if (seen !== expected)
        begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // Address and data are offered together and released independently.
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge i_clock);
        awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d; wstrb <= s; bready <= 1;
        do
        begin
            @(posedge i_clock);
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 0;
    endtask : bus_write

    task automatic bus_read(input logic [31:0] a);
        @(posedge i_clock);
        arvalid <= 1; araddr <= a; rready <= 1;
        do
        begin
            @(posedge i_clock);
            if (arvalid && arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 0;
    endtask : bus_read

    // Sampling at the edge itself avoids racing a flag set at that same edge.
    task automatic watch_wake(input int cycles, output logic seen);
        seen = 1'b0;
        repeat (cycles)
        begin
            @(posedge i_clock);
            if (stop_wakeup === 1'b1)
                seen = 1'b1;
        end
    endtask : watch_wake

    task automatic fire_source(input logic [5:0] idx);
        @(posedge i_clock);
        fire <= 1; fire_index <= idx;
        @(posedge i_clock);
        fire <= 0;
        repeat (2) @(posedge i_clock);
    endtask : fire_source

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_values();
        bus_read(ADDR_CFG_A);
        check(rd, 32'h2020_2020);
        bus_read(ADDR_CFG_B);
        check(rd, 32'h0000_0000);
        check(stop_wakeup, 1'b0);
        bus_write(ADDR_CFG_A, 32'hFFFF_FFFF, 4'hF);
        bus_read(ADDR_CFG_A);
        check(rd, 32'h3131_3131);
    endtask : test_reset_values

    task automatic test_pending_clear();
        fire_source(6'h00); fire_source(6'h25); fire_source(6'h3F);
        bus_read(ADDR_PENDING_HI);
        check(rd, 32'h8000_0020);
        // Upper bits carry junk that must not widen the index.
        bus_write(ADDR_PENDING_CLEAR, 32'hFFFF_FFE5, 4'hF);
        check(pending, 64'h8000_0000_0000_0001);
        bus_write(ADDR_PENDING_CLEAR, 32'h0000_0005, 4'hF);
        check(pending, 64'h8000_0000_0000_0001);
        bus_read(ADDR_PENDING_CLEAR);
        check(rd, 32'h0000_0000);
        // Without its low byte lane the write names no source at all.
        bus_write(ADDR_PENDING_CLEAR, 32'h0000_0000, 4'hE);
        check(pending, 64'h8000_0000_0000_0001);
        bus_write(ADDR_PENDING_CLEAR, 32'h0000_003F, 4'hF);
        check(pending, 64'h0000_0000_0000_0001);
        bus_read(ADDR_PENDING_LO);
        check(rd, 32'h0000_0001);
    endtask : test_pending_clear

    // The pin starts where its code detects nothing, then moves to its condition.
    task automatic test_wake_codes();
        logic [1:0] code;
        logic       seen;
        for (int n = 0; n < 4; n++)
            for (int c = 0; c < 8; c++)
            begin
                code = c[1:0];
                pin_level[n] <= ~code[0];
                bus_write(ADDR_CFG_A, {24'h0, 2'h0, code, 3'h0, c[2]} << (8 * n), 4'hF);
                bus_read(ADDR_CFG_A);
                check(rd, {24'h0, 2'h0, code, 3'h0, c[2]} << (8 * n));
                repeat (4) @(posedge i_clock);
                watch_wake(4, seen);
                check(seen, 1'b0);
                pin_level[n] <= code[0];
                watch_wake(4, seen);
                check(seen, c[2]);
                watch_wake(4, seen);
                check(seen, c[2] & ~code[1]);
            end
        bus_write(ADDR_CFG_A, 32'h2020_2020, 4'hF);
        pin_level <= 4'h0;
    endtask : test_wake_codes

    task automatic test_status_mask();
        bus_write(ADDR_MASK, 32'h0, 4'hF);
        bus_write(ADDR_CFG_A, 32'h0031_0000, 4'hF);
        bus_read(ADDR_STATUS);
        pin_level[2] <= 1;
        repeat (5) @(posedge i_clock);
        check(irq, 1'b0);
        bus_read(ADDR_STATUS);
        check(rd, 32'h0000_0004);
        bus_read(ADDR_STATUS);
        check(rd, 32'h0000_0000);
        bus_write(ADDR_MASK, 32'h4, 4'hF);
        bus_read(ADDR_MASK);
        check(rd, 32'h0000_0004);
        pin_level[2] <= 0;
        @(posedge i_clock);
        pin_level[2] <= 1;
        repeat (5) @(posedge i_clock);
        check(irq, 1'b1);
        bus_read(ADDR_STATUS);
        check(rd, 32'h0000_0004);
        repeat (3) @(posedge i_clock);
        check(irq, 1'b0);
    endtask : test_status_mask

    task automatic test_unmapped();
        bus_write(32'hFFFF_E064, 32'hFFFF_FFFF, 4'hF);
        check(rsp, RESP_SLVERR);
        bus_read(32'hFFFF_E064);
        check(rsp, RESP_SLVERR);
        check(rd, 32'h0);
        bus_write(ADDR_CFG_B, 32'hA5A5_5A5A, 4'h5);
        check(rsp, RESP_OKAY);
        bus_read(ADDR_CFG_B);
        check(rsp, RESP_OKAY);
        check(rd, 32'h00A5_005A);
    endtask : test_unmapped

    initial
    begin
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1;
        repeat (5) @(posedge i_clock);
        test_reset_values();
        test_pending_clear();
        test_wake_codes();
        test_status_mask();
        test_unmapped();
        finish_test();
    end

    initial
    begin
        #5000000;
        failures++;
        finish_test();
    end
endmodule : test_irq_clear_and_stop_wakeup
